// ### bench/test_uart_baud_and_receiver.sv
// Self-checking testbench of the baud generator and receiver
`timescale 1ns/1ps
module test_uart_baud_and_receiver;
	import ubar_pkg::*;
	// ==========================================================
	// Signals and constants
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	ubar_axi_req_type  axi_req = '0;
	ubar_axi_resp_type axi_resp;
	logic              sline;
	logic              sout;
	logic              dreq;
	logic              dack = 1'b0;
	logic              treq;
	logic              irq;
	logic [7:0]        ddata;
	int                error_cnt = 0;
	int                n_tests = 0;
	localparam logic [31:0] ON  = 32'h1 << STS_RECEIVE_ON;
	localparam logic [31:0] AV  = 32'h1 << STS_CHAR_AVAILABLE;
	localparam logic [31:0] OV  = 32'h1 << STS_OVERRUN;
	localparam logic [31:0] FR  = 32'h1 << STS_FRAMING;
	localparam logic [31:0] PE  = 32'h1 << STS_PARITY;
	localparam logic [31:0] EN  = 32'h1 << CMD_RECEIVE_ENABLE;
	localparam logic [31:0] DIS = 32'h1 << CMD_RECEIVE_DISABLE;
	localparam logic [31:0] RST = 32'h1 << CMD_RECEIVE_RESET;
	localparam logic [31:0] CLR = 32'h1 << CMD_STATUS_CLEAR;

	always #12.5 aclk = ~aclk;

	ubar_uart_rx i_ubar_uart_rx (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.axi_req         (axi_req),
		.axi_resp        (axi_resp),
		.serial_in_line  (sline),
		.serial_out_line (sout),
		.rx_dma_request  (dreq),
		.rx_dma_ack      (dack),
		.rx_dma_data     (ddata),
		.tx_dma_request  (treq),
		.irq             (irq)
	);

	ubar_serial_sender i_ubar_serial_sender (
		.aclk (aclk),
		.line (sline)
	);

	// ==========================================================
	// Shared tasks
	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (axi_req.awvalid && axi_resp.awready)
				axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_resp.wready)
				axi_req.wvalid <= 1'b0;
		end while (axi_resp.bvalid !== 1'b1);
		check($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, axi_resp.bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (axi_req.arvalid && axi_resp.arready)
				axi_req.arvalid <= 1'b0;
		end while (axi_resp.rvalid !== 1'b1);
		check($sformatf("rdata@%h", a), e, axi_resp.rdata);
		check($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, axi_resp.rresp});
	endtask

	task automatic rx_expect(input logic [7:0] d, input logic pon,
		input logic pb, input logic stp, input int cpb, input logic [31:0] st);
		i_ubar_serial_sender.send(d, pon, pb, stp, cpb);
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS, st, RESP_OKAY);
		rd(OFF_RECEIVE, {24'h0, d}, RESP_OKAY);
	endtask

	function automatic logic pbit(input logic [7:0] d, input int m);
		case (m)
			0: return ^d;
			1: return ~^d;
			2: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Scenarios
	task automatic t_bus();
		rd(OFF_DIVISOR, 32'h0, RESP_OKAY);
		rd(OFF_FORMAT, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(OFF_RECEIVE, 32'h55, RESP_SLVERR);
		wr(OFF_FORMAT, 32'h3 << FMT_PARITY_LSB, RESP_OKAY);
		rd(OFF_FORMAT, 32'h3 << FMT_PARITY_LSB, RESP_OKAY);
		wr(OFF_FORMAT, 32'h4 << FMT_PARITY_LSB, RESP_OKAY);
		wr(OFF_DIVISOR, 32'h1, RESP_OKAY);
		check("serial_out", 32'h1, {31'h0, sout});
		check("tx_dma_req", 32'h0, {31'h0, treq});
		// Receiver still off: the frame must leave no trace
		i_ubar_serial_sender.send(8'h96, 1'b0, 1'b0, 1'b1, 16);
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		rd(OFF_RECEIVE, 32'h0, RESP_OKAY);
	endtask

	task automatic t_receive();
		wr(OFF_COMMAND, EN, RESP_OKAY);
		rd(OFF_STATUS, ON, RESP_OKAY);
		i_ubar_serial_sender.send(8'ha5, 1'b0, 1'b0, 1'b1, 16);
		repeat (4) @(posedge aclk);
		check("dma_req", 32'h1, {31'h0, dreq});
		check("dma_data", 32'ha5, {24'h0, ddata});
		check("irq", 32'h1, {31'h0, irq});
		rd(OFF_STATUS, ON | AV, RESP_OKAY);
		rd(OFF_RECEIVE, 32'ha5, RESP_OKAY);
		rd(OFF_STATUS, ON, RESP_OKAY);
		i_ubar_serial_sender.send(8'h5a, 1'b0, 1'b0, 1'b1, 16);
		repeat (4) @(posedge aclk);
		dack <= 1'b1;
		@(posedge aclk);
		dack <= 1'b0;
		repeat (2) @(posedge aclk);
		check("dma_req", 32'h0, {31'h0, dreq});
		rd(OFF_STATUS, ON, RESP_OKAY);
	endtask

	task automatic t_overrun();
		i_ubar_serial_sender.send(8'h11, 1'b0, 1'b0, 1'b1, 16);
		rx_expect(8'h22, 1'b0, 1'b0, 1'b1, 16, ON | AV | OV);
		rd(OFF_STATUS, ON | OV, RESP_OKAY);
		wr(OFF_COMMAND, CLR, RESP_OKAY);
		rd(OFF_STATUS, ON, RESP_OKAY);
	endtask

	task automatic t_parity();
		logic [7:0] d;
		logic       p;
		d = 8'h6b;
		for (int m = 0; m < 4; m++) begin
			p = pbit(d, m);
			wr(OFF_FORMAT, m << FMT_PARITY_LSB, RESP_OKAY);
			rx_expect(d, 1'b1, p, 1'b1, 16, ON | AV);
			rx_expect(d, 1'b1, ~p, 1'b1, 16, ON | AV | PE);
			rx_expect(d, 1'b1, p, 1'b1, 16, ON | AV | PE);
			wr(OFF_COMMAND, CLR, RESP_OKAY);
			rd(OFF_STATUS, ON, RESP_OKAY);
		end
		wr(OFF_FORMAT, 32'h4 << FMT_PARITY_LSB, RESP_OKAY);
	endtask

	task automatic t_framing();
		rx_expect(8'h81, 1'b0, 1'b0, 1'b0, 16, ON | AV | FR);
		rx_expect(8'h42, 1'b0, 1'b0, 1'b1, 16, ON | AV | FR);
		wr(OFF_COMMAND, CLR, RESP_OKAY);
		rd(OFF_STATUS, ON, RESP_OKAY);
	endtask

	task automatic t_glitch();
		i_ubar_serial_sender.glitch(7);
		repeat (200) @(posedge aclk);
		rd(OFF_STATUS, ON, RESP_OKAY);
		rx_expect(8'hc4, 1'b0, 1'b0, 1'b1, 16, ON | AV);
	endtask

	task automatic t_divisor();
		wr(OFF_DIVISOR, 32'h2, RESP_OKAY);
		rx_expect(8'he7, 1'b0, 1'b0, 1'b1, 32, ON | AV);
		rd(OFF_DIVISOR, 32'h2, RESP_OKAY);
		wr(OFF_DIVISOR, 32'h10000, RESP_OKAY);
		rd(OFF_DIVISOR, 32'h10000, RESP_OKAY);
		wr(OFF_DIVISOR, 32'h0, RESP_OKAY);
		i_ubar_serial_sender.send(8'h3e, 1'b0, 1'b0, 1'b1, 16);
		wr(OFF_DIVISOR, 32'h1, RESP_OKAY);
		rd(OFF_STATUS, ON, RESP_OKAY);
	endtask

	task automatic t_disable();
		fork
			i_ubar_serial_sender.send(8'h3c, 1'b0, 1'b0, 1'b1, 16);
			begin
				repeat (40) @(posedge aclk);
				wr(OFF_COMMAND, DIS, RESP_OKAY);
			end
		join
		// Frame sent after the stop: the receiver is off and keeps 0x3c
		i_ubar_serial_sender.send(8'h99, 1'b0, 1'b0, 1'b1, 16);
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS, AV, RESP_OKAY);
		rd(OFF_RECEIVE, 32'h3c, RESP_OKAY);
	endtask

	task automatic t_rxreset();
		wr(OFF_COMMAND, EN, RESP_OKAY);
		fork
			i_ubar_serial_sender.send(8'hc3, 1'b0, 1'b0, 1'b1, 16);
			begin
				repeat (60) @(posedge aclk);
				wr(OFF_COMMAND, RST, RESP_OKAY);
			end
		join
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		rd(OFF_RECEIVE, 32'h3c, RESP_OKAY);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_bus();
		t_receive();
		t_overrun();
		t_parity();
		t_framing();
		t_glitch();
		t_divisor();
		t_disable();
		t_rxreset();
		conclude();
	end

	initial begin
		repeat (60000) @(posedge aclk);
		error_cnt++;
		conclude();
	end
endmodule

// ### bench/ubar_serial_sender.sv
// Model of the remote asynchronous sender that drives the receive line
`timescale 1ns/1ps
module ubar_serial_sender (
	input  wire logic aclk,
	output logic      line
);
	// ==========================================================
	// Line driving
	initial line = 1'b1;

	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge aclk);
	endtask

	task automatic send(input logic [7:0] d, input logic pon,
		input logic pb, input logic stp, input int cpb);
		@(posedge aclk);
		hold(1'b0, cpb);
		for (int i = 0; i < 8; i++) begin
			hold(d[i], cpb);
		end
		if (pon) begin
			hold(pb, cpb);
		end
		// A low stop is shortened so the tail never looks like a start
		if (stp) begin
			hold(1'b1, cpb);
		end else begin
			hold(1'b0, cpb * 3 / 4);
		end
		line <= 1'b1;
	endtask

	task automatic glitch(input int n);
		@(posedge aclk);
		hold(1'b0, n);
		line <= 1'b1;
	endtask
endmodule

// ### hdl/ubar_pkg.sv
// Shared constants, types and helpers for the baud generator and receiver
package ubar_pkg;

	// ==========================================================
	// Bus shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_COMMAND  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FORMAT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_RECEIVE  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_DIVISOR  = 8'h20;

	// ==========================================================
	// Field positions
	localparam int CMD_RECEIVE_RESET   = 2;
	localparam int CMD_RECEIVE_ENABLE  = 4;
	localparam int CMD_RECEIVE_DISABLE = 5;
	localparam int CMD_STATUS_CLEAR    = 8;
	localparam int FMT_PARITY_LSB      = 9;
	localparam int FMT_PARITY_W        = 3;
	localparam int STS_CHAR_AVAILABLE  = 0;
	localparam int STS_OVERRUN         = 5;
	localparam int STS_FRAMING         = 6;
	localparam int STS_PARITY          = 7;
	localparam int STS_RECEIVE_ON      = 16;

	// ==========================================================
	// Reset values and sizes
	localparam int DIV_W = 17;
	localparam logic [DIV_W-1:0]        DIVISOR_RESET = 17'h00000;
	localparam logic [FMT_PARITY_W-1:0] PARITY_RESET  = 3'h0;
	localparam logic [7:0]              HOLDING_RESET = 8'h00;

	// ==========================================================
	// Receiver timing, in ticks of the 16x sampling clock, and the index of the last data bit
	localparam logic [4:0] START_LOW_MAX = 5'h07;
	localparam logic [4:0] FIRST_SAMPLE  = 5'h18;
	localparam logic [4:0] BIT_TICKS     = 5'h10;
	localparam logic [3:0] LAST_BIT      = 4'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		PAR_EVEN  = 3'h0,
		PAR_ODD   = 3'h1,
		PAR_SPACE = 3'h2,
		PAR_MARK  = 3'h3,
		PAR_NONE  = 3'h4
	} ubar_parity_type;

	typedef enum logic [5:0] {
		ST_OFF    = 6'h01,
		ST_IDLE   = 6'h02,
		ST_START  = 6'h04,
		ST_DATA   = 6'h08,
		ST_PARITY = 6'h10,
		ST_STOP   = 6'h20
	} ubar_rx_state_type;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} ubar_axi_req_type;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} ubar_axi_resp_type;

	// ==========================================================
	// Helpers
	function automatic logic [DATA_W-1:0] ubar_strobe_mask(
		input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic ubar_expected_parity(input logic [7:0] d,
		input ubar_parity_type p);
		case (p)
			PAR_EVEN:  return ^d;
			PAR_ODD:   return ~^d;
			PAR_MARK:  return 1'b1;
			default:   return 1'b0;
		endcase
	endfunction

endpackage

// ### hdl/ubar_uart_rx.sv
// Baud rate generator, receiver and AXI4-Lite register slave of the port
// Contract
// - Sampling tick from clock over divisor, shared
// - Divisor zero stops ticks, port inactive
// - Divisor reaches 65536
// - Asynchronous only, 8-bit characters, optional parity
// - No timeout, no guard, independent directions
// - Disabled after reset; enable starts hunting
// - Disable: idle stops now, else after stop
// - Receiver reset aborts and disables at once
// - Start valid only if low over 7 ticks
// - First sample 24 ticks after falling edge
// - Later samples every 16 ticks
// - Full character loads holding, sets available
// - Reading holding register clears available
// - Completion while available sets overrun
// - Overrun holds until status clear command
// - Parity mismatch sets parity error with available
// - Parity error sticks until status clear
// - Even, odd, mark and space parity
// - Receive DMA request and interrupt output; transmit DMA request tied low
// - Low stop bit sets sticky framing error
// - Available flag requests receive DMA read
// - Status clear drops parity, framing, overrun
`timescale 1ns/1ps
module ubar_uart_rx #(
	parameter int DIV_W = ubar_pkg::DIV_W
) (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire ubar_pkg::ubar_axi_req_type  axi_req,
	output ubar_pkg::ubar_axi_resp_type      axi_resp,
	input  wire logic                     serial_in_line,
	output logic                          serial_out_line,
	output logic                          rx_dma_request,
	input  wire logic                     rx_dma_ack,
	output logic [7:0]                    rx_dma_data,
	output logic                          tx_dma_request,
	output logic                          irq
);
	import ubar_pkg::*;

	// ==========================================================
	// Register bus slave
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0]        w_strb;
	logic              bvalid;
	logic [1:0]        bresp;
	logic              rvalid;
	logic [DATA_W-1:0] rdata;
	logic [1:0]        rresp;

	wire aw_take = axi_req.awvalid & ~aw_held & ~bvalid;
	wire w_take  = axi_req.wvalid & ~w_held & ~bvalid;
	wire ar_take = axi_req.arvalid & ~rvalid;
	wire wr_commit = aw_held & w_held & ~bvalid;

	wire [DATA_W-1:0] wr_mask = ubar_strobe_mask(w_strb);
	wire [DATA_W-1:0] wr_bits = w_data & wr_mask;
	wire wr_cmd = wr_commit & (aw_addr == OFF_COMMAND);
	wire wr_fmt = wr_commit & (aw_addr == OFF_FORMAT);
	wire wr_div = wr_commit & (aw_addr == OFF_DIVISOR);
	wire wr_ok  = (aw_addr == OFF_COMMAND) | (aw_addr == OFF_FORMAT)
		| (aw_addr == OFF_DIVISOR);

	wire cmd_rst = wr_cmd & wr_bits[CMD_RECEIVE_RESET];
	wire cmd_en  = wr_cmd & wr_bits[CMD_RECEIVE_ENABLE];
	wire cmd_dis = wr_cmd & wr_bits[CMD_RECEIVE_DISABLE];
	wire cmd_sta = wr_cmd & wr_bits[CMD_STATUS_CLEAR];

	assign axi_resp.awready = ~aw_held & ~bvalid;
	assign axi_resp.wready  = ~w_held & ~bvalid;
	assign axi_resp.bvalid  = bvalid;
	assign axi_resp.bresp   = bresp;
	assign axi_resp.arready = ~rvalid;
	assign axi_resp.rvalid  = rvalid;
	assign axi_resp.rdata   = rdata;
	assign axi_resp.rresp   = rresp;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req.awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= axi_req.wdata;
				w_strb <= axi_req.wstrb;
			end
			if (wr_commit) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && axi_req.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software registers
	logic [DIV_W-1:0]  rate_divisor;
	ubar_parity_type   parity_type;

	wire [DATA_W-1:0] fmt_word = {{(DATA_W-FMT_PARITY_LSB-FMT_PARITY_W){1'b0}},
		parity_type, {FMT_PARITY_LSB{1'b0}}};
	wire [DATA_W-1:0] div_word = {{(DATA_W-DIV_W){1'b0}}, rate_divisor};
	wire [DATA_W-1:0] next_fmt_word = wr_bits | (fmt_word & ~wr_mask);
	wire [DATA_W-1:0] next_div_word = wr_bits | (div_word & ~wr_mask);
	wire parity_on = parity_type < PAR_NONE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rate_divisor <= DIVISOR_RESET;
			parity_type  <= ubar_parity_type'(PARITY_RESET);
		end else begin
			if (wr_div)
				rate_divisor <= next_div_word[DIV_W-1:0];
			if (wr_fmt)
				parity_type <= ubar_parity_type'(
					next_fmt_word[FMT_PARITY_LSB +: FMT_PARITY_W]);
		end
	end

	// ==========================================================
	// Baud rate generator: one tick per divisor clocks, 16 per bit
	logic [DIV_W-1:0] div_cnt;
	wire tick = (rate_divisor != '0) && (div_cnt >= rate_divisor - 1'b1);

	always_ff @(posedge aclk) begin
		if (!aresetn || rate_divisor == '0 || tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	// ==========================================================
	// Receiver
	ubar_rx_state_type state;
	ubar_rx_state_type next_state;
	logic [4:0] tick_cnt;
	logic [4:0] next_cnt;
	logic [3:0] bit_idx;
	logic [3:0] next_idx;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic       par_bit;
	logic       next_par;
	logic       stop_pending;
	logic       next_stop;
	logic       char_done;
	logic [7:0] holding;
	logic       char_available;
	logic       overrun_flag;
	logic       parity_error_flag;
	logic       framing_error_flag;

	wire bit_due = tick && (tick_cnt == BIT_TICKS);
	wire leave_now = stop_pending | cmd_dis;
	wire rd_holding = ar_take && (axi_req.araddr == OFF_RECEIVE);
	wire par_bad = parity_on
		&& (par_bit != ubar_expected_parity(shift, parity_type));

	// No timeout or guard; transmitter is independent
	always_comb begin
		next_state = state;
		next_cnt   = tick_cnt;
		next_idx   = bit_idx;
		next_shift = shift;
		next_par   = par_bit;
		next_stop  = stop_pending;
		char_done  = 1'b0;
		// Disable mid-character waits for the stop bit
		if (cmd_dis && state != ST_OFF && state != ST_IDLE)
			next_stop = 1'b1;
		case (state)
			ST_OFF: begin
				if (cmd_en && !cmd_dis)
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (cmd_dis) begin
					next_state = ST_OFF;
				end else if (tick && !serial_in_line) begin
					next_state = ST_START;
					next_cnt   = 5'h01;
				end
			end
			ST_START: begin
				if (tick) begin
					if (tick_cnt <= START_LOW_MAX && serial_in_line) begin
						next_state = leave_now ? ST_OFF : ST_IDLE;
						next_stop  = 1'b0;
					end else if (tick_cnt == FIRST_SAMPLE) begin
						next_shift = {serial_in_line, shift[7:1]};
						next_idx   = 4'h1;
						next_cnt   = 5'h01;
						next_state = ST_DATA;
					end else begin
						next_cnt = tick_cnt + 5'h01;
					end
				end
			end
			ST_DATA: begin
				if (bit_due) begin
					next_shift = {serial_in_line, shift[7:1]};
					next_cnt   = 5'h01;
					if (bit_idx == LAST_BIT)
						next_state = parity_on ? ST_PARITY : ST_STOP;
					else
						next_idx = bit_idx + 4'h1;
				end else if (tick) begin
					next_cnt = tick_cnt + 5'h01;
				end
			end
			ST_PARITY: begin
				if (bit_due) begin
					next_par   = serial_in_line;
					next_cnt   = 5'h01;
					next_state = ST_STOP;
				end else if (tick) begin
					next_cnt = tick_cnt + 5'h01;
				end
			end
			ST_STOP: begin
				if (bit_due) begin
					char_done  = 1'b1;
					next_state = leave_now ? ST_OFF : ST_IDLE;
					next_stop  = 1'b0;
				end else if (tick) begin
					next_cnt = tick_cnt + 5'h01;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		if (cmd_rst) begin
			next_state = ST_OFF;
			next_stop  = 1'b0;
			next_cnt   = 5'h00;
			next_idx   = 4'h0;
			char_done  = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= ST_OFF;
			tick_cnt     <= 5'h00;
			bit_idx      <= 4'h0;
			shift        <= 8'h00;
			par_bit      <= 1'b0;
			stop_pending <= 1'b0;
		end else begin
			state        <= next_state;
			tick_cnt     <= next_cnt;
			bit_idx      <= next_idx;
			shift        <= next_shift;
			par_bit      <= next_par;
			stop_pending <= next_stop;
		end
	end

	// ==========================================================
	// Holding register and status flags; a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			holding            <= HOLDING_RESET;
			char_available     <= 1'b0;
			overrun_flag       <= 1'b0;
			parity_error_flag  <= 1'b0;
			framing_error_flag <= 1'b0;
		end else begin
			// Read by software or DMA clears
			if (char_done) begin
				holding        <= shift;
				char_available <= 1'b1;
			end else if (rd_holding || rx_dma_ack) begin
				char_available <= 1'b0;
			end
			if (char_done && char_available)
				overrun_flag <= 1'b1;
			else if (cmd_sta)
				overrun_flag <= 1'b0;
			if (char_done && par_bad)
				parity_error_flag <= 1'b1;
			else if (cmd_sta)
				parity_error_flag <= 1'b0;
			// Sender ends with a high stop bit
			// Status clear drops all three errors
			if (char_done && !serial_in_line)
				framing_error_flag <= 1'b1;
			else if (cmd_sta)
				framing_error_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Read path
	wire [DATA_W-1:0] sts_word = (DATA_W'(char_available) << STS_CHAR_AVAILABLE)
		| (DATA_W'(overrun_flag) << STS_OVERRUN)
		| (DATA_W'(framing_error_flag) << STS_FRAMING)
		| (DATA_W'(parity_error_flag) << STS_PARITY)
		| (DATA_W'(state != ST_OFF) << STS_RECEIVE_ON);
	wire sel_fmt = axi_req.araddr == OFF_FORMAT;
	wire sel_sts = axi_req.araddr == OFF_STATUS;
	wire sel_rcv = axi_req.araddr == OFF_RECEIVE;
	wire sel_div = axi_req.araddr == OFF_DIVISOR;
	wire rd_ok   = sel_fmt | sel_sts | sel_rcv | sel_div;
	wire [DATA_W-1:0] rd_word = sel_fmt ? fmt_word
		: sel_sts ? sts_word
		: sel_rcv ? {{(DATA_W-8){1'b0}}, holding}
		: sel_div ? div_word
		: '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && axi_req.rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// System outputs; the transmitter sits outside this block
	// DMA requests and interrupt
	assign rx_dma_request  = char_available;
	assign rx_dma_data     = holding;
	assign tx_dma_request  = 1'b0;
	assign serial_out_line = 1'b1;
	assign irq = char_available | overrun_flag | parity_error_flag
		| framing_error_flag;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_div_zero_still: assert property (
		rate_divisor == '0 |-> !tick)
		else $error("tick while divisor is zero");
	a_tick_spacing: assert property (
		tick && rate_divisor > 1 && !wr_div |=> !tick)
		else $error("ticks too close");
	a_reset_aborts: assert property (
		cmd_rst |=> state == ST_OFF)
		else $error("receiver reset ignored");
	a_idle_disable: assert property (
		cmd_dis && state == ST_IDLE && !cmd_rst |=> state == ST_OFF)
		else $error("idle disable not immediate");
	a_enable_hunt: assert property (
		state == ST_OFF && cmd_en && !cmd_dis && !cmd_rst
		|=> state == ST_IDLE)
		else $error("enable did not start hunt");
	a_glitch_drop: assert property (
		state == ST_START && tick && tick_cnt <= START_LOW_MAX
		&& serial_in_line && !cmd_rst |=> state inside {ST_IDLE, ST_OFF})
		else $error("short low taken as start");
	a_first_sample: assert property (
		state == ST_START && tick && tick_cnt == FIRST_SAMPLE && !cmd_rst
		|=> state == ST_DATA && bit_idx == 4'h1)
		else $error("first sample misplaced");
	a_char_loaded: assert property (
		char_done |=> char_available && holding == $past(shift))
		else $error("character not loaded");
	a_read_clears: assert property (
		(rd_holding || rx_dma_ack) && !char_done |=> !char_available)
		else $error("read did not clear available");
	a_overrun_set: assert property (
		char_done && char_available |=> overrun_flag)
		else $error("overrun missed");
	a_parity_set: assert property (
		char_done && par_bad |=> parity_error_flag && char_available)
		else $error("parity error missed");
	a_framing_set: assert property (
		char_done && !serial_in_line |=> framing_error_flag)
		else $error("framing error missed");
	a_status_clear: assert property (
		cmd_sta && !char_done |=> !overrun_flag && !parity_error_flag
		&& !framing_error_flag)
		else $error("status clear failed");
	a_off_holds: assert property (
		state == ST_OFF |=> $stable(holding))
		else $error("holding changed while off");

endmodule
